// file: logic/vpp_defs.svh
`ifndef VPP_DEFS_SVH
`define VPP_DEFS_SVH
// Register byte offsets
`define VPP_OFF_CTRL 12'h000
`define VPP_OFF_CLAMP 12'h004
`define VPP_OFF_HDRV 12'h008
`define VPP_OFF_WINX 12'h00c
`define VPP_OFF_WINY 12'h010
`define VPP_OFF_PSRC 12'h014
`define VPP_OFF_GRAB 12'h018
`define VPP_OFF_STAT 12'h01c
`define VPP_OFF_LUTA 12'h020
`define VPP_OFF_LUTD 12'h024
// Control register fields
`define VPP_C_MAP 0
`define VPP_C_ISYNC 1
`define VPP_C_BREF 3:2
`define VPP_C_HDEC 5:4
`define VPP_C_VDEC 7:6
`define VPP_C_COLOUR 8
`define VPP_C_YCC 9
`define VPP_C_SPLIT 11:10
`define VPP_C_ARM 12
`define VPP_C_SEL 15:13
// Low and high count fields of two-field registers, then table address, source mask and grab request fields
`define VPP_LO 0
`define VPP_HI 16
`define VPP_LUTA_IDX 7:0
`define VPP_LUTA_TBL 10:8
`define VPP_PSRC_MASK 5:0
`define VPP_GRAB_REQ 2:0
// Reset values
`define VPP_RST_CTRL 16'h0000
`define VPP_RST_OFF '0
`define VPP_RST_SIZE '1
`define VPP_RST_HCNT '1
`define VPP_RST_PERIOD 12'h3ff
`define VPP_RST_HDW 12'h040
`define VPP_RST_PSRC 6'h07
// Constants of the data path
`define VPP_NTBL 3'h6
`define VPP_CBASE 3'h3
`define VPP_CHROMA 8'h80
`define VPP_PAD 8'h00
`define VPP_LAST 2'h3
`endif

// file: logic/vpp_pkg.sv
package vpp_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vpp_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } vpp_apb_rsp_t;
    typedef struct packed {
        logic valid;
        logic sol;
        logic sof;
        logic [2:0][7:0] d;
    } vpp_pix_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } vpp_word_t;
    typedef struct packed {
        logic [2:0] valid;
        logic [2:0][31:0] data;
    } vpp_host_t;
    typedef enum logic [1:0] {BREF_AUTO = 2'h0, BREF_ON = 2'h1, BREF_OFF = 2'h2} vpp_bref_t;
    typedef enum logic [1:0] {SPLIT_OFF = 2'h0, SPLIT_HORZ = 2'h1, SPLIT_VERT = 2'h2} vpp_split_t;
    typedef enum logic [2:0] {G_IDLE = 3'b001, G_ARMED = 3'b010, G_RUN = 3'b100} vpp_grab_t;
endpackage

// file: logic/vpp_top.sv
// Behaviour
// (RULE_01) Clamp pulse sits in the horizontal back porch of every line.
// (RULE_02) Clamp start and end count from the incoming horizontal sync edge.
// (RULE_03) With internal sync, clamp positions count from the generated drive edge.
// (RULE_04) Clamp pulse lasts from programmed start to programmed end.
// (RULE_05) Six separate lookup tables, one per input, each loaded on its own.
// (RULE_06) Each table maps 8-bit pixels to 8-bit pixels through 256 entries.
// (RULE_07) Only the window at programmed offsets and size is passed.
// (RULE_08) Software programs a window width that is a multiple of four.
// (RULE_09) Software programs an even window height for interlaced sources.
// (RULE_10) Window offsets reset to zero so the whole image passes.
// (RULE_11) Decimation by two, four or eight, both directions.
// (RULE_12) Horizontal and vertical factors are chosen independently.
// (RULE_13) Horizontal decimation keeps the first pixel of each group.
// (RULE_14) Vertical decimation keeps the first line of each group.
// (RULE_15) Mono packs four pixels per word, earliest in the low byte.
// (RULE_16) Colour words are zero, third, second, first channel from top.
// (RULE_17) Luminance expansion gives 16-bit samples with chroma byte 0x80.
// (RULE_18) The chroma byte is added only on the host path.
// (RULE_19) Luminance expansion never applies to colour data.
// (RULE_20) Planar mode sends each channel to its own destination.
// (RULE_21) Software picks planar inputs with a bit mask, bit 0 first input.
// (RULE_22) With planar arming, capture starts only after all three grab requests.
// (RULE_23) Every incoming sample is an unsigned byte per channel.
// (RULE_24) With the table off, pixels pass to the window unchanged.
// (RULE_25) Clamp can be forced on, forced off, or automatic.
`timescale 1ns/1ps
`default_nettype none
`include "vpp_defs.svh"
module vpp_top #(
    parameter int CNT_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire vpp_pkg::vpp_apb_req_t apb_req,
    output var vpp_pkg::vpp_apb_rsp_t apb_rsp,
    input wire logic horizontal_sync_in,
    input wire vpp_pkg::vpp_pix_t vid_in,
    output logic horizontal_drive_out,
    output logic clamp_out,
    output var vpp_pkg::vpp_word_t mem_out,
    output var vpp_pkg::vpp_host_t host_out
);
    import vpp_pkg::*;

    // Counts must fit the high half of a register word
    generate
        if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
            $error("vpp_top: CNT_W must lie between 8 and 16");
        end
    endgenerate

    typedef struct packed {
        logic [15:0] ctrl;
        logic [CNT_W-1:0] clamp_start;
        logic [CNT_W-1:0] clamp_end;
        logic [CNT_W-1:0] hd_period;
        logic [CNT_W-1:0] hd_width;
        logic [CNT_W-1:0] x_off;
        logic [CNT_W-1:0] x_size;
        logic [CNT_W-1:0] y_off;
        logic [CNT_W-1:0] y_size;
        logic [5:0] src_mask;
        logic [2:0] lut_tbl;
        logic [7:0] lut_idx;
        logic [5:0][255:0][7:0] lut;
        logic s1_hs;
        logic s2_hs;
        logic hs_d;
        vpp_pix_t s1_pix;
        vpp_pix_t s2_pix;
        logic [CNT_W-1:0] hcnt;
        logic [CNT_W-1:0] hdcnt;
        logic clamp;
        logic hd;
        logic [CNT_W-1:0] x;
        logic [CNT_W-1:0] y;
        logic p1_valid;
        logic [2:0][7:0] p1_d;
        logic [1:0] pack_cnt;
        logic [31:0] pack_word;
        logic [2:0][31:0] plane_word;
        logic ycc_half;
        logic [7:0] ycc_lo;
        vpp_word_t mem;
        vpp_host_t host;
        logic [2:0] pend;
        vpp_grab_t gst;
        logic [31:0] prdata;
        logic perr;
    } vpp_state_t;

    vpp_state_t st_ff;
    vpp_state_t nxt_st;

    // Group mask of a decimation code: keep when the low bits are zero
    function automatic logic [2:0] dec_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

    // Table used by channel k: the selected input, or its connector base plus k
    function automatic logic [2:0] tbl_of(input logic [2:0] sel, input logic colour,
                                          input logic [1:0] k);
        logic [2:0] base;
        base = (sel >= `VPP_CBASE) ? `VPP_CBASE : 3'h0;
        return colour ? 3'(base + {1'b0, k}) : sel;
    endfunction

    logic setup;
    logic wr;
    logic hs_edge;
    logic hd_edge;
    logic ref_edge;
    logic colour;
    logic ycc_on;
    logic start_now;
    logic run_now;
    logic inwin;
    logic keep;
    logic [CNT_W-1:0] cx;
    logic [CNT_W-1:0] cy;
    logic [CNT_W-1:0] rx;
    logic [CNT_W-1:0] ry;
    logic [2:0] pend_now;
    logic [2:0][7:0] mapped;
    logic [2:0] tsel;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign hs_edge = st_ff.s2_hs & ~st_ff.hs_d;
    assign hd_edge = st_ff.ctrl[`VPP_C_ISYNC] & (st_ff.hdcnt == '0);
    assign ref_edge = st_ff.ctrl[`VPP_C_ISYNC] ? hd_edge : hs_edge; // [RULE_02] [RULE_03]
    assign colour = st_ff.ctrl[`VPP_C_COLOUR];
    assign ycc_on = st_ff.ctrl[`VPP_C_YCC] & ~colour; // [RULE_19]
    assign pend_now = st_ff.pend | ((wr && apb_req.paddr == `VPP_OFF_GRAB) ?
                                    apb_req.pwdata[`VPP_GRAB_REQ] : 3'h0);
    assign start_now = (st_ff.gst == G_ARMED) & st_ff.s2_pix.valid & st_ff.s2_pix.sof;
    assign run_now = start_now | ((st_ff.gst == G_RUN) & ~st_ff.s2_pix.sof);

    // Position of the incoming pixel within the frame
    assign cx = st_ff.s2_pix.sol ? '0 : st_ff.x;
    assign cy = st_ff.s2_pix.sof ? '0 : (st_ff.s2_pix.sol ? st_ff.y + 1'b1 : st_ff.y);
    assign rx = cx - st_ff.x_off;
    assign ry = cy - st_ff.y_off;
    assign inwin = (cx >= st_ff.x_off) && (rx < st_ff.x_size)
                && (cy >= st_ff.y_off) && (ry < st_ff.y_size); // [RULE_07]
    assign keep = st_ff.s2_pix.valid & run_now & inwin
                & ((rx[2:0] & dec_mask(st_ff.ctrl[`VPP_C_HDEC])) == 3'h0) // [RULE_11] [RULE_13]
                & ((ry[2:0] & dec_mask(st_ff.ctrl[`VPP_C_VDEC])) == 3'h0); // [RULE_12] [RULE_14]

    // Point transform per channel; out-of-range table selects pass through
    always_comb begin
        tsel = 3'h0;
        for (int k = 0; k < 3; k++) begin
            tsel = tbl_of(st_ff.ctrl[`VPP_C_SEL], colour, 2'(k));
            if (st_ff.ctrl[`VPP_C_MAP] && tsel < `VPP_NTBL) begin
                mapped[k] = st_ff.lut[tsel][st_ff.s2_pix.d[k]]; // [RULE_05] [RULE_06]
            end else begin
                mapped[k] = st_ff.s2_pix.d[k]; // [RULE_24] [RULE_23]
            end
        end
    end

    // Next state of the whole block
    always_comb begin
        logic [31:0] rd;
        logic [31:0] word;
        logic hit;
        rd = 32'h0000_0000;
        word = 32'h0000_0000;
        hit = 1'b1;
        nxt_st = st_ff;

        // Pin inputs pass two flip-flops; only the second stage is used
        nxt_st.s1_hs = horizontal_sync_in;
        nxt_st.s2_hs = st_ff.s1_hs;
        nxt_st.hs_d = st_ff.s2_hs;
        nxt_st.s1_pix = vid_in;
        nxt_st.s2_pix = st_ff.s1_pix;

        // Register reads are latched in the setup cycle
        unique case (apb_req.paddr)
            `VPP_OFF_CTRL: rd = {16'h0000, st_ff.ctrl};
            `VPP_OFF_CLAMP: rd = 32'(st_ff.clamp_start) | (32'(st_ff.clamp_end) << `VPP_HI);
            `VPP_OFF_HDRV: rd = 32'(st_ff.hd_period) | (32'(st_ff.hd_width) << `VPP_HI);
            `VPP_OFF_WINX: rd = 32'(st_ff.x_off) | (32'(st_ff.x_size) << `VPP_HI);
            `VPP_OFF_WINY: rd = 32'(st_ff.y_off) | (32'(st_ff.y_size) << `VPP_HI);
            `VPP_OFF_PSRC: rd = 32'(st_ff.src_mask);
            `VPP_OFF_GRAB: rd = 32'(st_ff.pend);
            `VPP_OFF_STAT: rd = {22'h0, st_ff.hd, st_ff.clamp, 5'h0, st_ff.gst};
            `VPP_OFF_LUTA: rd = {21'h0, st_ff.lut_tbl, st_ff.lut_idx};
            `VPP_OFF_LUTD: rd = (st_ff.lut_tbl < `VPP_NTBL) ?
                                32'(st_ff.lut[st_ff.lut_tbl][st_ff.lut_idx]) : 32'h0;
            default: hit = 1'b0;
        endcase
        if (setup) begin
            nxt_st.prdata = rd;
            nxt_st.perr = ~hit;
        end

        // Register writes take effect in the access cycle
        if (wr) begin
            unique case (apb_req.paddr)
                `VPP_OFF_CTRL: nxt_st.ctrl = apb_req.pwdata[15:0];
                `VPP_OFF_CLAMP: begin
                    nxt_st.clamp_start = apb_req.pwdata[`VPP_LO +: CNT_W];
                    nxt_st.clamp_end = apb_req.pwdata[`VPP_HI +: CNT_W];
                end
                `VPP_OFF_HDRV: begin
                    nxt_st.hd_period = apb_req.pwdata[`VPP_LO +: CNT_W];
                    nxt_st.hd_width = apb_req.pwdata[`VPP_HI +: CNT_W];
                end
                `VPP_OFF_WINX: begin
                    nxt_st.x_off = apb_req.pwdata[`VPP_LO +: CNT_W];
                    nxt_st.x_size = apb_req.pwdata[`VPP_HI +: CNT_W];
                end
                `VPP_OFF_WINY: begin
                    nxt_st.y_off = apb_req.pwdata[`VPP_LO +: CNT_W];
                    nxt_st.y_size = apb_req.pwdata[`VPP_HI +: CNT_W];
                end
                `VPP_OFF_PSRC: nxt_st.src_mask = apb_req.pwdata[`VPP_PSRC_MASK];
                `VPP_OFF_LUTA: begin
                    nxt_st.lut_tbl = apb_req.pwdata[`VPP_LUTA_TBL];
                    nxt_st.lut_idx = apb_req.pwdata[`VPP_LUTA_IDX];
                end
                `VPP_OFF_LUTD: begin
                    // Auto-increment lets software stream a table in 256 writes
                    if (st_ff.lut_tbl < `VPP_NTBL) begin
                        nxt_st.lut[st_ff.lut_tbl][st_ff.lut_idx] = apb_req.pwdata[7:0]; // [RULE_05]
                    end
                    nxt_st.lut_idx = st_ff.lut_idx + 8'h01; // [RULE_06]
                end
                default: ;
            endcase
        end

        // Internal horizontal drive generator
        if (st_ff.ctrl[`VPP_C_ISYNC]) begin
            nxt_st.hdcnt = (st_ff.hdcnt >= st_ff.hd_period) ? '0 : st_ff.hdcnt + 1'b1;
        end else begin
            nxt_st.hdcnt = '1;
        end
        nxt_st.hd = st_ff.ctrl[`VPP_C_ISYNC] & (nxt_st.hdcnt < st_ff.hd_width);

        // Position since the reference edge saturates so no clamp before the first edge
        if (ref_edge) begin
            nxt_st.hcnt = '0; // [RULE_02] [RULE_03]
        end else if (st_ff.hcnt != '1) begin
            nxt_st.hcnt = st_ff.hcnt + 1'b1;
        end
        unique case (vpp_bref_t'(st_ff.ctrl[`VPP_C_BREF]))
            BREF_AUTO: nxt_st.clamp = (nxt_st.hcnt >= st_ff.clamp_start)
                                   && (nxt_st.hcnt < st_ff.clamp_end); // [RULE_01] [RULE_04]
            BREF_ON: nxt_st.clamp = 1'b1; // [RULE_25]
            default: nxt_st.clamp = 1'b0; // [RULE_25]
        endcase

        // Frame position counters
        if (st_ff.s2_pix.valid) begin
            nxt_st.x = cx + 1'b1;
            nxt_st.y = cy;
        end

        // Grab sequencing; a request written as a capture starts is kept
        nxt_st.pend = pend_now;
        unique case (st_ff.gst)
            G_IDLE: begin
                if (st_ff.ctrl[`VPP_C_ARM] ? (&pend_now) : (|pend_now)) begin // [RULE_22]
                    nxt_st.gst = G_ARMED;
                    nxt_st.pend = 3'h0;
                end
            end
            G_ARMED: begin
                if (start_now) begin
                    nxt_st.gst = G_RUN;
                end
            end
            G_RUN: begin
                if (st_ff.s2_pix.valid && st_ff.s2_pix.sof) begin
                    nxt_st.gst = G_IDLE;
                end
            end
        endcase

        // Window and decimation result
        nxt_st.p1_valid = keep;
        nxt_st.p1_d = mapped;

        // Word formation toward memory and host
        nxt_st.mem.valid = 1'b0;
        nxt_st.host.valid = 3'h0;
        if (st_ff.p1_valid) begin
            nxt_st.pack_cnt = st_ff.pack_cnt + 2'h1; // [RULE_08]
            if (colour) begin
                word = {`VPP_PAD, st_ff.p1_d[2], st_ff.p1_d[1], st_ff.p1_d[0]}; // [RULE_16]
                nxt_st.mem.valid = 1'b1;
                nxt_st.mem.data = word;
                if (vpp_split_t'(st_ff.ctrl[`VPP_C_SPLIT]) != SPLIT_OFF) begin
                    for (int k = 0; k < 3; k++) begin
                        nxt_st.plane_word[k] = {st_ff.p1_d[k], st_ff.plane_word[k][31:8]};
                        nxt_st.host.data[k] = nxt_st.plane_word[k];
                    end
                    if (st_ff.pack_cnt == `VPP_LAST) begin
                        // [RULE_20] [RULE_21]
                        for (int k = 0; k < 3; k++) begin
                            nxt_st.host.valid[k] = st_ff.src_mask[tbl_of(
                                st_ff.ctrl[`VPP_C_SEL], 1'b1, 2'(k))];
                        end
                    end
                end else begin
                    nxt_st.host.valid[0] = 1'b1;
                    nxt_st.host.data[0] = word;
                end
            end else begin
                nxt_st.pack_word = {st_ff.p1_d[0], st_ff.pack_word[31:8]}; // [RULE_15]
                if (st_ff.pack_cnt == `VPP_LAST) begin
                    nxt_st.mem.valid = 1'b1;
                    nxt_st.mem.data = nxt_st.pack_word;
                    if (!ycc_on) begin
                        nxt_st.host.valid[0] = 1'b1;
                        nxt_st.host.data[0] = nxt_st.pack_word;
                    end
                end
                nxt_st.ycc_half = ~st_ff.ycc_half;
                nxt_st.ycc_lo = st_ff.p1_d[0];
                if (ycc_on && st_ff.ycc_half) begin
                    // Chroma exists only here; memory keeps luminance bytes
                    nxt_st.host.valid[0] = 1'b1; // [RULE_17] [RULE_18]
                    nxt_st.host.data[0] = {`VPP_CHROMA, st_ff.p1_d[0], `VPP_CHROMA, st_ff.ycc_lo};
                end
            end
        end
        // Packing restarts with each capture
        if (start_now) begin
            nxt_st.pack_cnt = 2'h0;
            nxt_st.ycc_half = 1'b0;
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.ctrl <= `VPP_RST_CTRL;
            st_ff.x_off <= `VPP_RST_OFF; // [RULE_10]
            st_ff.y_off <= `VPP_RST_OFF; // [RULE_10]
            st_ff.x_size <= `VPP_RST_SIZE;
            st_ff.y_size <= `VPP_RST_SIZE;
            st_ff.hd_period <= CNT_W'(`VPP_RST_PERIOD);
            st_ff.hd_width <= CNT_W'(`VPP_RST_HDW);
            st_ff.src_mask <= `VPP_RST_PSRC;
            st_ff.hcnt <= `VPP_RST_HCNT;
            st_ff.hdcnt <= `VPP_RST_HCNT;
            st_ff.gst <= G_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs
    assign apb_rsp.prdata = st_ff.prdata;
    assign apb_rsp.pready = apb_req.psel & apb_req.penable;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & st_ff.perr;
    assign horizontal_drive_out = st_ff.hd;
    assign clamp_out = st_ff.clamp;
    assign mem_out = st_ff.mem;
    assign host_out = st_ff.host;

    // Helper: length of the current clamp pulse
    logic [CNT_W-1:0] clen_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clen_ff <= '0;
        end else begin
            clen_ff <= st_ff.clamp ? clen_ff + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_clamp_off: assert property ( // [RULE_25]
        st_ff.ctrl[`VPP_C_BREF] == BREF_OFF |=> !clamp_out)
        else $error("clamp pulse while forced off");
    chk_clamp_start: assert property ( // [RULE_02]
        $rose(clamp_out) && $past(st_ff.ctrl[`VPP_C_BREF]) == BREF_AUTO
        && $stable(st_ff.clamp_start) |-> st_ff.hcnt == st_ff.clamp_start)
        else $error("clamp began away from programmed start");
    chk_clamp_width: assert property ( // [RULE_04]
        $fell(clamp_out) && $past(st_ff.ctrl[`VPP_C_BREF]) == BREF_AUTO
        && $stable(st_ff.clamp_end) && $past(st_ff.hcnt) != '1 && !$past(ref_edge)
        |-> clen_ff == CNT_W'(st_ff.clamp_end - st_ff.clamp_start))
        else $error("clamp width differs from end minus start");
    chk_hd_ref: assert property ( // [RULE_03]
        st_ff.ctrl[`VPP_C_ISYNC] && $rose(horizontal_drive_out) |=> st_ff.hcnt == '0)
        else $error("clamp position not counted from drive edge");
    chk_hs_ref: assert property ( // [RULE_02]
        !st_ff.ctrl[`VPP_C_ISYNC] && st_ff.s2_hs && !st_ff.hs_d |=> st_ff.hcnt == '0)
        else $error("clamp position not counted from sync edge");
    chk_lut_bypass: assert property ( // [RULE_24]
        !st_ff.ctrl[`VPP_C_MAP] && keep |=> st_ff.p1_valid && st_ff.p1_d == $past(st_ff.s2_pix.d))
        else $error("pixel altered with table off");
    chk_pack_order: assert property ( // [RULE_15]
        mem_out.valid && !$past(colour) |-> mem_out.data[31:24] == $past(st_ff.p1_d[0]))
        else $error("latest pixel not in top byte");
    chk_pad_zero: assert property ( // [RULE_16]
        mem_out.valid && $past(colour) |-> mem_out.data[31:24] == `VPP_PAD
        && mem_out.data[7:0] == $past(st_ff.p1_d[0]))
        else $error("padded word layout wrong");
    chk_ycc_chroma: assert property ( // [RULE_17]
        host_out.valid[0] && $past(ycc_on) |-> host_out.data[0][31:24] == `VPP_CHROMA
        && host_out.data[0][15:8] == `VPP_CHROMA)
        else $error("chroma byte not constant");
    chk_ycc_colour: assert property ( // [RULE_19]
        host_out.valid[0] && $past(colour) && $past(st_ff.ctrl[`VPP_C_SPLIT]) == SPLIT_OFF
        |-> host_out.data[0][31:24] == `VPP_PAD)
        else $error("expansion applied to colour data");
    chk_arm_third: assert property ( // [RULE_22]
        st_ff.gst == G_IDLE && st_ff.ctrl[`VPP_C_ARM] && !(&pend_now) |=> st_ff.gst == G_IDLE)
        else $error("capture armed before third request");
    chk_window_in: assert property ( // [RULE_07]
        st_ff.p1_valid |-> $past(inwin) && $past(run_now))
        else $error("pixel passed outside window");

    cov_clamp: cover property ($rose(clamp_out));
    cov_mono_word: cover property (mem_out.valid && !colour);
    cov_ycc: cover property (host_out.valid[0] && ycc_on);
    cov_planar: cover property (&host_out.valid);
    cov_run: cover property (st_ff.gst == G_ARMED ##1 st_ff.gst == G_RUN);
endmodule
`default_nettype wire

// file: testbench/vpp_host_sink.sv
`timescale 1ns/1ps
`default_nettype none
module vpp_host_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire vpp_pkg::vpp_host_t host_out
);
    import vpp_pkg::*;
    // One queue per destination plane; this sink never stalls the transfer
    logic [31:0] q0[$];
    logic [31:0] q1[$];
    logic [31:0] q2[$];
    // Each lane lands in its own buffer, as a planar host would place it
    always @(posedge pclk) begin
        if (presetn && host_out.valid[0] === 1'b1) q0.push_back(host_out.data[0]);
        if (presetn && host_out.valid[1] === 1'b1) q1.push_back(host_out.data[1]);
        if (presetn && host_out.valid[2] === 1'b1) q2.push_back(host_out.data[2]);
    end
endmodule
`default_nettype wire

// file: testbench/test_video_pixel_pipeline.sv
`timescale 1ns/1ps
`default_nettype none
module test_video_pixel_pipeline;
    import vpp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic hs = 1'b0;
    vpp_apb_req_t req = '0;
    vpp_apb_rsp_t rsp;
    vpp_pix_t vid = '0;
    vpp_word_t mem;
    vpp_host_t host;
    logic clamp;
    logic hd;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] mq[$];
    vpp_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .horizontal_sync_in(hs), .vid_in(vid), .horizontal_drive_out(hd), .clamp_out(clamp),
        .mem_out(mem), .host_out(host));
    vpp_host_sink sink (.pclk(pclk), .presetn(presetn), .host_out(host));
    // 200 MHz pixel clock
    initial forever #2.5 pclk = ~pclk;
    // Frame memory side simply records every word
    always @(posedge pclk) if (mem.valid === 1'b1) mq.push_back(mem.data);
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Setup, then access held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        // Ends when pready is seen high; if it never is, only the bench's hang guard ends this wait
        while (rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask
    // One grabbed frame of n pixels in lines of 16, then a lone start pixel closes the grab
    task automatic frame(input logic [15:0] ctrl, input int n);
        wr(12'h000, {16'h0, ctrl});
        wr(12'h018, 32'h1);
        mq.delete();
        sink.q0.delete();
        sink.q1.delete();
        sink.q2.delete();
        for (int i = 0; i <= n; i++) begin
            @(posedge pclk);
            vid <= {1'b1, i % 16 == 0 || i == n, i == 0 || i == n,
                8'(i + 33), 8'(i + 17), 8'(i + 1)};
        end
        @(posedge pclk);
        vid <= '0;
        repeat (12) @(posedge pclk);
    endtask
    // Clamp and drive high cycles after one reference edge; no sync pulse under internal drive
    task automatic clamp_len(input logic [15:0] ctrl, input int exp, input int exp_hd);
        int n;
        int m;
        n = 0;
        m = 0;
        wr(12'h000, {16'h0, ctrl});
        @(posedge pclk);
        hs <= !ctrl[1];
        @(posedge pclk);
        hs <= 1'b0;
        repeat (20) @(posedge pclk) begin
            if (clamp === 1'b1) n++;
            if (hd === 1'b1) m++;
        end
        chk(32'(n), 32'(exp));
        chk(32'(m), 32'(exp_hd));
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h000, 32'h0, 1'b0);
        rdchk(12'h00c, 32'h0fff0000, 1'b0);
        rdchk(12'h010, 32'h0fff0000, 1'b0);
        rdchk(12'h030, 32'h0, 1'b1);
        wr(12'h004, 32'h00050002);
        clamp_len(16'h0000, 3, 0);
        clamp_len(16'h0002, 3, 20);
        clamp_len(16'h0004, 20, 0);
        clamp_len(16'h0008, 0, 0);
        frame(16'h0000, 4);
        chk(mq.pop_front(), 32'h04030201);
        for (int k = 1; k < 4; k++) begin
            frame(16'(k << 4), 4 << k);
            chk(mq.pop_front(), {8'(3 * (1 << k) + 1), 8'(2 * (1 << k) + 1), 8'((1 << k) + 1), 8'h01});
        end
        // Second line dropped, first line halved
        frame(16'h0050, 32);
        chk(32'(mq.size()), 32'h2);
        chk(mq.pop_front(), 32'h07050301);
        wr(12'h020, 32'h0);
        for (int e = 0; e < 5; e++) wr(12'h024, {24'h0, ~8'(e)});
        frame(16'h0001, 4);
        chk(mq.pop_front(), 32'hfbfcfdfe);
        wr(12'h014, 32'h7);
        frame(16'h0500, 4);
        chk(mq.pop_front(), 32'h00211101);
        chk(sink.q0.pop_front(), 32'h04030201);
        chk(sink.q1.pop_front(), 32'h14131211);
        chk(sink.q2.pop_front(), 32'h24232221);
        frame(16'h0200, 4);
        chk(mq.pop_front(), 32'h04030201);
        chk(sink.q0.pop_front(), 32'h80028001);
        chk(sink.q0.pop_front(), 32'h80048003);
        // Window of four pixels from x 4; even height
        wr(12'h00c, 32'h00040004);
        wr(12'h010, 32'h00020000);
        frame(16'h0000, 8);
        chk(mq.pop_front(), 32'h08070605);
        // Armed only by the third grab request
        wr(12'h000, 32'h00001000);
        wr(12'h018, 32'h1);
        wr(12'h018, 32'h2);
        rdchk(12'h01c, 32'h1, 1'b0);
        wr(12'h018, 32'h4);
        rdchk(12'h01c, 32'h2, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
